/* File: src/wdl_pkg.sv */
// constants for the locked watchdog timer
//
// Behaviour
// - 32-bit counter decrements per slow tick
// - at zero set status and reload
// - second unserviced expiry asserts reset if enabled
// - period is reload value plus one ticks
// - interrupt clear clears status and reloads
// - enable low halts; rising restarts from reload
// - control bit one gates reset output
// - key write unlocks; other values lock writes
// - reload write restarts count; resets all ones
// - value register reads live count, ignores writes
// - registers decode at their fixed offsets
// - any clear write acts; clear reads zero
// - raw status bit0 unmasked, writes ignored
// - masked status is raw and enable, drives irq
// - lock reads one when locked, zero otherwise
package wdl_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_RELOAD = 12'h000;
  localparam logic [11:0] OFF_COUNT = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_ICLR = 12'h00c;
  localparam logic [11:0] OFF_RAW = 12'h010;
  localparam logic [11:0] OFF_MASKED = 12'h014;
  localparam logic [11:0] OFF_EVT = 12'h018;
  localparam logic [11:0] OFF_EVT_MASK = 12'h01c;
  localparam logic [11:0] OFF_GUARD = 12'hc00;

  // reset values and the unlock key
  localparam logic [31:0] RELOAD_RST = 32'hffffffff;
  localparam logic [31:0] WRITE_KEY = 32'h1acce551;

  // control and event field positions
  localparam int IRQ_EN_BIT = 0;
  localparam int REBOOT_EN_BIT = 1;
  localparam int EVT_EXPIRY_BIT = 0;
  localparam int EVT_BLOCKED_BIT = 1;
  localparam int EVT_W = 2;
  localparam int CTRL_W = 2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : wdl_pkg

/* File: src/wdl_top.sv */
// locked watchdog timer with axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module wdl_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // slow 32.768 khz square wave from rc or crystal oscillator
  input wire logic slow_clk_in,
  // level interrupt and one-cycle system reset request
  output logic irq,
  output logic wdt_reset
);

  // whole module state
  typedef struct packed {
    // write side of the register bus
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    // read side of the register bus
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // slow clock filter
    logic sync1;
    logic sync2;
    logic sync3;
    logic slow_lvl;
    // counter, control and lock
    logic [31:0] current_count;
    logic [31:0] reload_reg;
    logic [1:0] ctrl;
    logic raw_irq_flag;
    logic locked;
    // events and outputs
    logic [1:0] evt;
    logic [1:0] evt_mask;
    logic irq_line;
    logic reboot;
  } wdl_state_t;

  wdl_state_t state_reg;
  wdl_state_t state_next;

  // merge written bytes into an old word
  function automatic logic [31:0] wdl_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    // copy only the lanes whose strobe is set
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction : wdl_merge

  // offset inside the block, low address bits dropped
  function automatic logic [11:0] wdl_offset(input logic [ADDR_W-1:0] addr);
    logic [11:0] off;
    off = 12'h000;
    // words are aligned, byte lane bits ignored
    off[ADDR_W-1:2] = addr[ADDR_W-1:2];
    return off;
  endfunction : wdl_offset

  // combinational helpers
  logic tick;
  logic expiry;
  logic masked_irq_flag;
  logic wr_go;
  logic [11:0] wr_off;
  logic [11:0] rd_off;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] merged_reload;
  logic [31:0] merged_ctrl;
  logic [31:0] merged_mask;
  logic enable_rise;

  // handshake outputs straight from state
  assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axi_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  // masked status for readback
  assign masked_irq_flag = state_reg.raw_irq_flag & state_reg.ctrl[wdl_pkg::IRQ_EN_BIT];

  // interrupt line and reset request straight from flops
  assign irq = state_reg.irq_line;
  assign wdt_reset = state_reg.reboot;

  // read decode
  always_comb begin
    // read word is chosen when the address is taken
    rd_off = wdl_offset(s_axi_araddr);
    rd_word = 32'h00000000;
    rd_hit = 1'b1;
    // unmapped offsets read zero and answer an error
    case (rd_off)
      wdl_pkg::OFF_RELOAD: rd_word = state_reg.reload_reg;
      wdl_pkg::OFF_COUNT: rd_word = state_reg.current_count;
      wdl_pkg::OFF_CTRL: rd_word[wdl_pkg::CTRL_W-1:0] = state_reg.ctrl;
      wdl_pkg::OFF_ICLR: rd_word = 32'h00000000;
      wdl_pkg::OFF_RAW: rd_word[0] = state_reg.raw_irq_flag;
      wdl_pkg::OFF_MASKED: rd_word[0] = masked_irq_flag;
      wdl_pkg::OFF_EVT: rd_word[wdl_pkg::EVT_W-1:0] = state_reg.evt;
      wdl_pkg::OFF_EVT_MASK: rd_word[wdl_pkg::EVT_W-1:0] = state_reg.evt_mask;
      wdl_pkg::OFF_GUARD: rd_word[0] = state_reg.locked;
      default: rd_hit = 1'b0;
    endcase
  end

  // next-state logic
  always_comb begin
    // hold everything; reset request lasts one cycle
    state_next = state_reg;
    state_next.reboot = 1'b0;

    // slow clock synchroniser, change taken when stages two and three agree
    // first stage feeds only the second
    state_next.sync1 = slow_clk_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    if (state_reg.sync2 == state_reg.sync3) begin
      state_next.slow_lvl = state_reg.sync3;
    end
    // tick only on the filtered rising edge
    tick = state_reg.sync2 && state_reg.sync3 && !state_reg.slow_lvl;

    // counting while enabled, one step per tick
    expiry = 1'b0;
    if (tick && state_reg.ctrl[wdl_pkg::IRQ_EN_BIT]) begin
      // zero reloads and raises the flag
      if (state_reg.current_count == 32'h00000000) begin
        expiry = 1'b1;
        state_next.current_count = state_reg.reload_reg;
        // flag still set: second expiry went unserviced
        if (state_reg.raw_irq_flag && state_reg.ctrl[wdl_pkg::REBOOT_EN_BIT]) begin
          state_next.reboot = 1'b1;
        end
      end else begin
        state_next.current_count = state_reg.current_count - 32'h00000001;
      end
    end

    // write address and data taken independently
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = wdl_offset(s_axi_awaddr);
    end
    // data may come before or after the address
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end

    // write execution once both halves are held
    wr_go = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    wr_off = state_reg.aw_addr;
    // byte-merged candidates for the strobed registers
    merged_reload = wdl_merge(state_reg.reload_reg, state_reg.w_data, state_reg.w_strb);
    merged_ctrl = wdl_merge({30'h00000000, state_reg.ctrl}, state_reg.w_data,
      state_reg.w_strb);
    merged_mask = wdl_merge({30'h00000000, state_reg.evt_mask}, state_reg.w_data,
      state_reg.w_strb);
    // no enable edge unless control is written
    enable_rise = 1'b0;
    if (wr_go) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = wdl_pkg::RESP_OKAY;
      // guard always writable so a locked block can reopen
      if (wr_off == wdl_pkg::OFF_GUARD) begin
        state_next.locked = (state_reg.w_data != wdl_pkg::WRITE_KEY);
      end else if (state_reg.locked) begin
        // blocked writes are dropped but still answered okay
        case (wr_off)
          wdl_pkg::OFF_RELOAD, wdl_pkg::OFF_COUNT, wdl_pkg::OFF_CTRL,
          wdl_pkg::OFF_ICLR, wdl_pkg::OFF_RAW, wdl_pkg::OFF_MASKED,
          wdl_pkg::OFF_EVT, wdl_pkg::OFF_EVT_MASK: begin
            // dropped write leaves a sticky event
            state_next.evt[wdl_pkg::EVT_BLOCKED_BIT] = 1'b1;
          end
          default: state_next.bresp = wdl_pkg::RESP_SLVERR;
        endcase
      end else begin
        case (wr_off)
          // new reload restarts the count at once
          wdl_pkg::OFF_RELOAD: begin
            state_next.reload_reg = merged_reload;
            state_next.current_count = merged_reload;
          end
          // enabling restarts from reload, not the old count
          wdl_pkg::OFF_CTRL: begin
            state_next.ctrl = merged_ctrl[wdl_pkg::CTRL_W-1:0];
            enable_rise = merged_ctrl[wdl_pkg::IRQ_EN_BIT] &&
              !state_reg.ctrl[wdl_pkg::IRQ_EN_BIT];
            if (enable_rise) begin
              state_next.current_count = state_reg.reload_reg;
            end
          end
          // any clear write drops the flag and reloads
          wdl_pkg::OFF_ICLR: begin
            state_next.raw_irq_flag = 1'b0;
            state_next.current_count = state_reg.reload_reg;
          end
          // event bits clear where a one is written
          wdl_pkg::OFF_EVT: begin
            state_next.evt = state_reg.evt & ~state_reg.w_data[wdl_pkg::EVT_W-1:0];
          end
          // event mask takes the strobed bytes
          wdl_pkg::OFF_EVT_MASK: begin
            state_next.evt_mask = merged_mask[wdl_pkg::EVT_W-1:0];
          end
          // read-only registers take and drop the write
          wdl_pkg::OFF_COUNT, wdl_pkg::OFF_RAW, wdl_pkg::OFF_MASKED: begin
            state_next.bresp = wdl_pkg::RESP_OKAY;
          end
          default: state_next.bresp = wdl_pkg::RESP_SLVERR;
        endcase
      end
    end

    // response stands until bready
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // expiry sets after any clear, so set wins
    if (expiry) begin
      state_next.raw_irq_flag = 1'b1;
      state_next.evt[wdl_pkg::EVT_EXPIRY_BIT] = 1'b1;
    end

    // read channel
    // a new address waits until the last answer is taken
    if (s_axi_arvalid && s_axi_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_word;
      state_next.rresp = rd_hit ? wdl_pkg::RESP_OKAY : wdl_pkg::RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end

    // interrupt line follows the state it is registered with
    state_next.irq_line = (state_next.raw_irq_flag & state_next.ctrl[wdl_pkg::IRQ_EN_BIT]) |
      (|(state_next.evt & state_next.evt_mask));
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // count and reload start from all ones
      state_reg <= '0;
      state_reg.reload_reg <= wdl_pkg::RELOAD_RST;
      state_reg.current_count <= wdl_pkg::RELOAD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : wdl_top

`default_nettype wire

/* File: tb/wdl_asserts.sv */
// port checks for the locked watchdog timer
`timescale 1ns/10ps
`default_nettype none
module wdl_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic wdt_reset
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // bus answers stand and come on time
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while bvalid");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write");
  // clear register reads zero
  AST_ICR_ZERO: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[11:2] == 10'h003 |=> s_axi_rdata == 32'h0) else $error("clear read");
  // reset is a single pulse while the interrupt stands
  AST_RST_PULSE: assert property (wdt_reset |=> !wdt_reset) else $error("long reset");
  AST_RST_IRQ: assert property ($rose(wdt_reset) |-> irq) else $error("reset no irq");
  COV_RST: cover property (wdt_reset);
  COV_IRQ: cover property ($rose(irq));
  COV_BSTALL: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : wdl_asserts
bind wdl_top wdl_asserts #(.ADDR_W(ADDR_W)) wdl_asserts_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq, .wdt_reset);
`default_nettype wire

/* File: tb/wdl_top_test.sv */
// self-checking bench for the locked watchdog timer
`timescale 1ns/10ps
`default_nettype none
module wdl_top_test;
  logic aclk, aresetn, slow_clk_in, irq, wdt_reset, s_axi_awvalid, s_axi_awready;
  logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, r, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] offs [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'hc00};
  int fails, samples_checked, pulses, seed;
  wdl_top wdl_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slow_clk_in, .irq, .wdt_reset);
  // 50 mhz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // count reset pulses
  always @(posedge aclk) begin
    if (wdt_reset === 1'b1) pulses++;
  end
  // expected count after n ticks from a fresh reload
  function automatic logic [31:0] cnt_after(input logic [31:0] ld, input int n);
    logic [31:0] c;
    c = ld;
    repeat (n) c = (c == 32'h0) ? ld : c - 32'h1;
    return c;
  endfunction : cnt_after
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // bus write; bready held high until bvalid is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : wr
  // bus read into r and resp; rready held until rvalid
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    r = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd
  // slow oscillator periods, six cycles each phase
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (6) @(posedge aclk);
      slow_clk_in <= 1'b1;
      repeat (6) @(posedge aclk);
      slow_clk_in <= 1'b0;
    end
    repeat (6) @(posedge aclk);
  endtask : ticks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // whole run is several hundred cycles; the time limit is 20000 cycles
  initial begin
    #400000;
    fails++;
    stop_test();
  end
  initial begin
    seed = 80814;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    slow_clk_in = 1'b0;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset value", i < 2 ? wdl_pkg::RELOAD_RST : 32'h0, r);
    end
    $display("test reset values done");
    repeat (4) begin
      d = $random(seed);
      wr(12'h000, d);
      rd(12'h000);
      chk("reload", d, r);
      rd(12'h004);
      chk("count restart", d, r);
    end
    wr(12'h004, ~d);
    rd(12'h004);
    chk("count write ignored", d, r);
    rd(12'h100);
    chk("unmapped resp", {30'h0, wdl_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(12'h100, 32'h0);
    chk("unmapped write resp", {30'h0, wdl_pkg::RESP_SLVERR}, {30'h0, resp});
    $display("test registers done");
    wr(12'h000, 32'h3);
    wr(12'h008, 32'h1);
    ticks(3);
    rd(12'h004);
    chk("count", cnt_after(32'h3, 3), r);
    chk("irq idle", 32'h0, {31'h0, irq});
    ticks(1);
    rd(12'h010);
    chk("raw", 32'h1, r);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h014);
    chk("masked", 32'h1, r);
    rd(12'h004);
    chk("reloaded", cnt_after(32'h3, 4), r);
    ticks(2);
    wr(12'h008, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(12'h014);
    chk("masked off", 32'h0, r);
    rd(12'h010);
    chk("raw kept", 32'h1, r);
    ticks(2);
    rd(12'h004);
    chk("halted", cnt_after(32'h3, 2), r);
    wr(12'h008, 32'h1);
    rd(12'h004);
    chk("enable restart", 32'h3, r);
    $display("test period done");
    wr(12'h010, 32'h0);
    rd(12'h010);
    chk("raw write ignored", 32'h1, r);
    ticks(1);
    rd(12'h004);
    chk("count on", 32'h2, r);
    wr(12'h00c, $random(seed));
    rd(12'h004);
    chk("clear reload", 32'h3, r);
    rd(12'h010);
    chk("raw cleared", 32'h0, r);
    rd(12'h00c);
    chk("clear reads", 32'h0, r);
    ticks(8);
    chk("no reset", 32'h0, pulses);
    wr(12'h008, 32'h3);
    ticks(4);
    chk("reset pulse", 32'h1, pulses);
    $display("test reset output done");
    d = $random(seed);
    wr(12'hc00, d == wdl_pkg::WRITE_KEY ? 32'h0 : d);
    rd(12'hc00);
    chk("locked", 32'h1, r);
    wr(12'h000, 32'h5);
    chk("blocked resp", {30'h0, wdl_pkg::RESP_OKAY}, {30'h0, resp});
    rd(12'h000);
    chk("blocked write", 32'h3, r);
    wr(12'hc00, wdl_pkg::WRITE_KEY);
    rd(12'hc00);
    chk("unlocked", 32'h0, r);
    wr(12'h000, 32'h5);
    rd(12'h000);
    chk("open write", 32'h5, r);
    $display("test lock done");
    wr(12'h008, 32'h0);
    wr(12'h01c, 32'h2);
    chk("event irq", 32'h1, {31'h0, irq});
    wr(12'h018, 32'h2);
    chk("event cleared", 32'h0, {31'h0, irq});
    rd(12'h018);
    chk("event left", 32'h1, r);
    $display("test events done");
    stop_test();
  end
endmodule : wdl_top_test
`default_nettype wire
